// [big_irq_gen.sv]
// Bridge interrupt generation: local and VME sources, routing, status and vector
// Function
// - Eight active-low local outputs, any routing allowed
// - Per-source local enable bit and route field
// - Enabled event drives routed output, sets status
// - Local status records events regardless of enable
// - Edge capture, except fail and local inputs level-held
// - Fail input asserts status, then output one cycle later
// - Fail clear ignored while input asserted
// - Fail inputs synchronised and filtered
// - VME level events on vector acquisition edges
// - Status and output hold until written one, soft requests until acknowledge
// - Lock grant with lock request raises event
// - Mailbox, monitor, soft, soft-ack local events
// - VME sources enabled, routed, levels shareable
// - Route level zero drives no request
// - VME event sets status; enabled drives level
// - Supply vector on matching acknowledge with chain
// - System controller ignores chain acknowledge input
// - Seven fixed-level soft bits plus mappable one
// - Vector lsb zero for software, software wins
// - Soft requests end at acknowledge, others hold
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "big_cfg.svh"
module big_irq_gen #(
	parameter int FILT_LEN = `BIG_FILT_LEN
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire big_pkg::big_addr_t reg_addr,
	input wire big_pkg::big_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output big_pkg::big_word_t reg_rdata,
	input wire logic acfail_n,
	input wire logic sysfail_n,
	input wire logic [7:0] local_irq_inputs_n,
	input wire logic vme_error_event,
	input wire logic local_abort_event,
	input wire logic dma_event,
	input wire logic [3:0] mailbox_accesses,
	input wire logic [3:0] location_monitor_hits,
	input wire logic [7:1] vector_acquired_levels,
	input wire logic bus_grant,
	input wire logic iack_strobe,
	input wire big_pkg::big_level_t iack_level,
	input wire logic iack_in_n,
	input wire logic syscon,
	output logic [7:0] local_irq_out_n,
	output logic [7:1] vme_irq_out_n,
	output logic vector_valid,
	output logic [7:0] vector_data
);
	import big_pkg::*;

	localparam int LN = `BIG_L_NSRC;
	localparam int VN = `BIG_V_NSRC;
	localparam int VM = `BIG_V_NMAP;

	if (FILT_LEN < 2) begin : g_chk
		$error("big_irq_gen: FILT_LEN must be at least 2");
	end

	// Software state
	logic [LN-1:0] len;
	logic [LN-1:0] lstat;
	big_word_t lroute [3];
	logic [VN-1:0] ven;
	logic [VN-1:0] vstat;
	big_word_t vroute [3];
	logic [7:1] outgoing_vector_reg;
	logic bus_lock_request;
	// Internal state
	logic [18:0] edge_prev;
	logic soft_acked;

	// Filtered fail levels
	logic acfail_f;
	logic sysfail_f;

	big_fail_filter #(.FILT_LEN(FILT_LEN)) u_acfail (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.fail_n(acfail_n),
		.fail_seen(acfail_f)
	);

	big_fail_filter #(.FILT_LEN(FILT_LEN)) u_sysfail (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.fail_n(sysfail_n),
		.fail_seen(sysfail_f)
	);

	// Address decode
	wire wr_len = reg_wr && (reg_addr == `BIG_OFF_LEN);
	wire wr_lstat = reg_wr && (reg_addr == `BIG_OFF_LSTAT);
	wire wr_ven = reg_wr && (reg_addr == `BIG_OFF_VEN);
	wire wr_vstat = reg_wr && (reg_addr == `BIG_OFF_VSTAT);
	wire wr_vector = reg_wr && (reg_addr == `BIG_OFF_VECTOR);
	wire wr_trig = reg_wr && (reg_addr == `BIG_OFF_TRIG);
	wire wr_ctrl = reg_wr && (reg_addr == `BIG_OFF_CTRL);
	wire [2:0] wr_lroute = {reg_wr && (reg_addr == `BIG_OFF_LROUTE2),
		reg_wr && (reg_addr == `BIG_OFF_LROUTE1), reg_wr && (reg_addr == `BIG_OFF_LROUTE0)};
	wire [2:0] wr_vroute = {reg_wr && (reg_addr == `BIG_OFF_VROUTE2),
		reg_wr && (reg_addr == `BIG_OFF_VROUTE1), reg_wr && (reg_addr == `BIG_OFF_VROUTE0)};

	// Soft triggers are pulses that exist only in the write cycle
	wire [31:0] trig = wr_trig ? reg_wdata : 32'h00000000;

	// Rising edges of all pulse-type sources; a held level fires once
	wire [18:0] edge_in = {bus_grant, mailbox_accesses, location_monitor_hits,
		vector_acquired_levels, dma_event, local_abort_event, vme_error_event};
	wire [18:0] rise = edge_in & ~edge_prev;
	wire [7:0] local_irq_out_n_act = ~local_irq_inputs_n;

	// Local set vector; the fail levels set every cycle they stand
	wire [LN-1:0] lset = {rise[18] & bus_lock_request, rise[17:14], rise[13:10],
		rise[9:3], rise[2], rise[1], rise[0], soft_acked, trig[`BIG_TRIG_LSOFT],
		sysfail_f, acfail_f};

	// VME set vector; local inputs are levels, so a clear cannot beat them
	wire [VN-1:0] vset = {trig[23:17], 1'b0, rise[17:14], trig[`BIG_V_SOFT],
		rise[1], rise[0], rise[2], local_irq_out_n_act};

	// Flat route fields, three bits each from four-bit nibbles
	logic [LN*3-1:0] lroute_flat;
	logic [VM*3-1:0] vroute_flat;

	for (genvar i = 0; i < LN; i++) begin : g_lmap
		assign lroute_flat[i*3 +: 3] = lroute[i/8][(i%8)*4 +: 3];
	end

	// Mailbox fields sit in the third map register, the rest fill in order
	for (genvar i = 0; i < VM; i++) begin : g_vmap
		localparam int R = (i < `BIG_V_MBOX) ? i / 8 : 2;
		localparam int N = (i < `BIG_V_MBOX) ? i % 8 : i - `BIG_V_MBOX;
		assign vroute_flat[i*3 +: 3] = vroute[R][N*4 +: 3];
	end

	// Only enabled sources reach the pins; status bits stay raw
	wire [LN-1:0] lact = lstat & len;
	wire [VM-1:0] vact = vstat[VM-1:0] & ven[VM-1:0];
	wire [7:1] sw_fix = vstat[23:17] & ven[23:17];
	logic [7:0] lhit;
	logic [7:1] vhit;

	big_route_fanout #(.N_SRC(LN), .N_OUT(8), .BASE(0)) u_lfan (
		.active(lact),
		.route(lroute_flat),
		.hit(lhit)
	);

	// BASE 1 leaves route value zero without any output
	big_route_fanout #(.N_SRC(VM), .N_OUT(7), .BASE(1)) u_vfan (
		.active(vact),
		.route(vroute_flat),
		.hit(vhit)
	);

	wire [7:1] vreq = vhit | sw_fix;

	// Acknowledge decode; the chain input is ignored as system controller
	wire [7:0] vreq8 = {vreq, 1'b0};
	wire [7:0] fix8 = {sw_fix, 1'b0};
	wire chain_ok = syscon || !iack_in_n;
	wire ack_take = iack_strobe && vreq8[iack_level] && chain_ok;
	wire sw_map_on = vact[`BIG_V_SOFT] && (vroute_flat[`BIG_V_SOFT*3 +: 3] == iack_level);
	wire sw_on_lvl = sw_map_on || fix8[iack_level];

	// Software requests on the acked level are retired by the acknowledge
	wire [6:0] fix_clr = (ack_take && fix8[iack_level]) ?
		7'(7'h01 << (iack_level - 3'h1)) : 7'h00;
	wire [VN-1:0] roak_clr = {fix_clr, 1'b0, 4'h0, ack_take && sw_map_on,
		11'h000};

	// Clears come from ones written and, for software requests, from the acknowledge; set beats clear
	wire [LN-1:0] lclr = wr_lstat ? reg_wdata[LN-1:0] : '0;
	wire [VN-1:0] vclr = (wr_vstat ? (reg_wdata[VN-1:0] & `BIG_VEN_MASK) : '0) | roak_clr;
	wire [LN-1:0] next_lstat = (lstat & ~lclr) | lset;
	wire [VN-1:0] next_vstat = (vstat & ~vclr) | vset;

	// Read mux; unmapped offsets read zero
	wire [31:0] rd_mux =
		(reg_addr == `BIG_OFF_LEN) ? {9'h000, len} :
		(reg_addr == `BIG_OFF_LSTAT) ? {9'h000, lstat} :
		(reg_addr == `BIG_OFF_LROUTE0) ? lroute[0] :
		(reg_addr == `BIG_OFF_LROUTE1) ? lroute[1] :
		(reg_addr == `BIG_OFF_LROUTE2) ? lroute[2] :
		(reg_addr == `BIG_OFF_VEN) ? {8'h00, ven} :
		(reg_addr == `BIG_OFF_VSTAT) ? {8'h00, vstat} :
		(reg_addr == `BIG_OFF_VROUTE0) ? vroute[0] :
		(reg_addr == `BIG_OFF_VROUTE1) ? vroute[1] :
		(reg_addr == `BIG_OFF_VROUTE2) ? vroute[2] :
		(reg_addr == `BIG_OFF_VECTOR) ? {24'h000000, outgoing_vector_reg, 1'b0} :
		(reg_addr == `BIG_OFF_CTRL) ? {31'h00000000, bus_lock_request} :
		32'h00000000;

	// Configuration registers
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			len <= '0;
			ven <= '0;
			outgoing_vector_reg <= 7'h00;
			bus_lock_request <= 1'b0;
		end else begin
			if (wr_len) len <= reg_wdata[LN-1:0];
			if (wr_ven) ven <= reg_wdata[VN-1:0] & `BIG_VEN_MASK;
			if (wr_vector) outgoing_vector_reg <= reg_wdata[7:1];
			if (wr_ctrl) bus_lock_request <= reg_wdata[0];
		end
	end

	// Route registers
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			for (int k = 0; k < 3; k++) begin
				lroute[k] <= `BIG_RST_WORD;
				vroute[k] <= `BIG_RST_WORD;
			end
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (wr_lroute[k]) lroute[k] <= reg_wdata & `BIG_ROUTE_MASK;
				if (wr_vroute[k]) vroute[k] <= reg_wdata & `BIG_ROUTE_MASK;
			end
		end
	end

	// Status, edge history and soft acknowledge event
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			lstat <= '0;
			vstat <= '0;
			edge_prev <= 19'h00000;
			soft_acked <= 1'b0;
		end else begin
			lstat <= next_lstat;
			vstat <= next_vstat;
			edge_prev <= edge_in;
			soft_acked <= ack_take && sw_on_lvl;
		end
	end

	// Registered pins, vector and read data
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			local_irq_out_n <= 8'hff;
			vme_irq_out_n <= 7'h7f;
			vector_valid <= 1'b0;
			vector_data <= 8'h00;
			reg_rdata <= 32'h00000000;
		end else begin
			local_irq_out_n <= ~lhit;
			vme_irq_out_n <= ~vreq;
			vector_valid <= ack_take;
			vector_data <= {outgoing_vector_reg, ~sw_on_lvl};
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	// Checks on the logic above
	a_zero_keeps: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_lstat |=> ((($past(lstat) & ~$past(reg_wdata[LN-1:0])) & ~lstat) == '0))
		else $error("local status bit lost on a zero write");

	a_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(vset != '0) |=> ((vstat & $past(vset)) == $past(vset)))
		else $error("vme event lost against a clear");

	a_fail_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(acfail_f && wr_lstat && reg_wdata[`BIG_L_ACFAIL]) |=> lstat[`BIG_L_ACFAIL])
		else $error("power-fail status cleared while input asserted");

	a_local_pin: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(lact != '0) |=> (local_irq_out_n != 8'hff))
		else $error("enabled local status did not drive a pin");

	a_status_raw: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(rise[0] && len[`BIG_L_VME_ERROR_EVENT] == 1'b0) |=> lstat[`BIG_L_VME_ERROR_EVENT])
		else $error("disabled source event missing from status");

	a_vme_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(vact == '0 && sw_fix == 7'h00) |=> (vme_irq_out_n == 7'h7f))
		else $error("vme request with no enabled routed source");

	a_vector_form: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ack_take |=> (vector_valid && vector_data[0] == !$past(sw_on_lvl)
		&& vector_data[7:1] == $past(outgoing_vector_reg)))
		else $error("acknowledge vector malformed");

	a_chain_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(iack_strobe && !syscon && iack_in_n) |=> !vector_valid)
		else $error("vector given without chain acknowledge");

	a_syscon_ack: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(iack_strobe && syscon && vreq8[iack_level]) |=> vector_valid)
		else $error("system controller failed to answer acknowledge");

	a_soft_retire: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(ack_take && sw_map_on) |=> (!vstat[`BIG_V_SOFT] ##1 lstat[`BIG_L_SOFTACK]))
		else $error("software request not retired by acknowledge");

	a_lock_event: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(rise[18] && bus_lock_request) |=> lstat[`BIG_L_LOCK])
		else $error("lock grant event not recorded");

	// Pins fall back once nothing enabled is left in status
	a_pin_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(lact == '0) |=> (local_irq_out_n == 8'hff))
		else $error("local pin held with no enabled status");

	// A held local input re-sets its bit, so a clear cannot drop it
	a_local_irq_out_n_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(local_irq_out_n_act != 8'h00) |=> ((vstat[7:0] & $past(local_irq_out_n_act)) == $past(local_irq_out_n_act)))
		else $error("held local input lost its vme status");

	// Fixed soft bits reach their own level two edges after the trigger
	a_fixed_soft: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(wr_trig && ((reg_wdata[23:17] & ven[23:17]) != 7'h00)) |=> ##1
		((vme_irq_out_n & $past(reg_wdata[23:17] & ven[23:17], 2)) == 7'h00))
		else $error("fixed soft request missing on its level");

	// An acknowledge at a level not requested must stay silent
	a_iack_refuse: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(iack_strobe && !vreq8[iack_level]) |=> !vector_valid)
		else $error("vector given for a level not requested");

	// Main scenarios
	c_soft_ack: cover property (@(posedge sys_clk) disable iff (!rst_b)
		ack_take && sw_on_lvl);
	c_hw_ack: cover property (@(posedge sys_clk) disable iff (!rst_b)
		ack_take && !sw_on_lvl);
	c_fail_clear: cover property (@(posedge sys_clk) disable iff (!rst_b)
		acfail_f && wr_lstat && reg_wdata[0]);
	c_lock: cover property (@(posedge sys_clk) disable iff (!rst_b)
		rise[18] && bus_lock_request);
endmodule // big_irq_gen

// [big_cfg.svh]
// Offsets, field positions, reset values and timing counts of the interrupt block
`ifndef BIG_CFG_SVH
`define BIG_CFG_SVH

// Register byte offsets
`define BIG_OFF_LEN 8'h00
`define BIG_OFF_LSTAT 8'h04
`define BIG_OFF_LROUTE0 8'h08
`define BIG_OFF_LROUTE1 8'h0c
`define BIG_OFF_LROUTE2 8'h10
`define BIG_OFF_VEN 8'h14
`define BIG_OFF_VSTAT 8'h18
`define BIG_OFF_VROUTE0 8'h1c
`define BIG_OFF_VROUTE1 8'h20
`define BIG_OFF_VROUTE2 8'h24
`define BIG_OFF_VECTOR 8'h28
`define BIG_OFF_TRIG 8'h2c
`define BIG_OFF_CTRL 8'h30

// Local source bit positions
`define BIG_L_ACFAIL 0
`define BIG_L_SYSFAIL 1
`define BIG_L_SOFT 2
`define BIG_L_SOFTACK 3
`define BIG_L_VME_ERROR_EVENT 4
`define BIG_L_LOCAL_ABORT_EVENT 5
`define BIG_L_DMA 6
`define BIG_L_VACQ 7
`define BIG_L_LM 14
`define BIG_L_MBOX 18
`define BIG_L_LOCK 22
`define BIG_L_NSRC 23

// VME source bit positions
`define BIG_V_LOCAL_IRQ_OUT_N 0
`define BIG_V_DMA 8
`define BIG_V_VME_ERROR_EVENT 9
`define BIG_V_LOCAL_ABORT_EVENT 10
`define BIG_V_SOFT 11
`define BIG_V_MBOX 12
`define BIG_V_NMAP 16
`define BIG_V_FIXSW 17
`define BIG_V_NSRC 24

// Masks, trigger layout and reset values
`define BIG_VEN_MASK 24'hfeffff
`define BIG_ROUTE_MASK 32'h77777777
`define BIG_TRIG_LSOFT 24
`define BIG_RST_WORD 32'h00000000
`define BIG_FILT_LEN 4

`endif

// [big_pkg.sv]
// Types shared by the interrupt block files
package big_pkg;
	typedef logic [7:0] big_addr_t;
	typedef logic [31:0] big_word_t;
	typedef logic [2:0] big_level_t;
endpackage

// [big_fail_filter.sv]
// Synchroniser and stability filter for one active-low fail input
`timescale 1ns/100ps
module big_fail_filter #(
	parameter int FILT_LEN = 4
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic fail_n,
	output logic fail_seen
);
	logic sync1;
	logic sync2;
	logic [7:0] cnt;

	if (FILT_LEN < 2 || FILT_LEN > 255) begin : g_chk
		$error("big_fail_filter: FILT_LEN out of range");
	end

	// Two flops, then the level must differ for FILT_LEN edges before it moves
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			cnt <= 8'h00;
			fail_seen <= 1'b0;
		end else begin
			sync1 <= ~fail_n;
			sync2 <= sync1;
			if (sync2 == fail_seen) begin
				cnt <= 8'h00;
			end else if (cnt == 8'(FILT_LEN - 1)) begin
				cnt <= 8'h00;
				fail_seen <= sync2;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
	end

	// A short glitch never reaches the output
	a_filter_stable: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(fail_seen) |-> ($past(sync2, 1) && $past(sync2, 2)))
		else $error("fail level passed filter without being stable");
endmodule // big_fail_filter

// [big_route_fanout.sv]
// Ors active sources onto the outputs their three-bit route fields select
`timescale 1ns/100ps
module big_route_fanout #(
	parameter int N_SRC = 8,
	parameter int N_OUT = 8,
	parameter int BASE = 0
) (
	input wire logic [N_SRC-1:0] active,
	input wire logic [N_SRC*3-1:0] route,
	output logic [N_OUT-1:0] hit
);
	if (N_OUT + BASE > 8 || N_SRC < 1) begin : g_chk
		$error("big_route_fanout: outputs do not fit a three-bit route");
	end

	// Route values below BASE select no output at all
	always_comb begin
		hit = '0;
		for (int j = 0; j < N_OUT; j++) begin
			for (int i = 0; i < N_SRC; i++) begin
				if (active[i] && (route[i*3 +: 3] == 3'(j + BASE))) begin
					hit[j] = 1'b1;
				end
			end
		end
	end
endmodule // big_route_fanout

// [big_vme_handler.sv]
// Far-side VME interrupt handler model that runs acknowledge cycles
`timescale 1ns/100ps
module big_vme_handler (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:1] vme_irq_out_n,
	input wire logic ack_go,
	input wire big_pkg::big_level_t ack_lvl,
	input wire logic [3:0] ack_dly,
	input wire logic chain_ok,
	output logic iack_strobe,
	output big_pkg::big_level_t iack_level,
	output logic iack_in_n
);
	import big_pkg::*;
	logic [3:0] wait_cnt;
	logic pending;
	// Wait models bus acquisition latency; only a requesting level is acknowledged
	always_ff @(posedge sys_clk) begin
		iack_strobe <= 1'b0;
		iack_in_n <= 1'b1; // Chain line idles high on its pull-up
		if (!rst_b) begin
			pending <= 1'b0;
			wait_cnt <= 4'h0;
			iack_level <= 3'h0;
		end else if (ack_go) begin
			pending <= 1'b1;
			wait_cnt <= ack_dly;
			iack_level <= ack_lvl;
		end else if (pending && wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else if (pending && !vme_irq_out_n[iack_level]) begin
			pending <= 1'b0;
			iack_strobe <= 1'b1;
			iack_in_n <= ~chain_ok;
		end else if (!pending) begin
			iack_level <= ~iack_level; // Level lines are meaningless when idle
		end
	end
endmodule // big_vme_handler

// [big_irq_gen_tb_top.sv]
// Self-checking bench of the bridge interrupt block
`timescale 1ns/100ps
`include "big_cfg.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module big_irq_gen_tb_top;
	import big_pkg::*;
	logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, bus_grant = 0, syscon = 0;
	big_addr_t reg_addr = 0;
	big_word_t reg_wdata = 0, reg_rdata, rd_val;
	logic [1:0] fail_n = 2'h3;
	logic [7:0] lin_n = 8'hff, local_irq_out_n, vector_data, vec_seen = 0;
	logic [17:0] src = 0;
	logic [7:1] vme_irq_out_n;
	logic iack_strobe, iack_in_n, vector_valid, ack_go = 0, chain_ok = 1;
	logic [3:0] ack_dly = 0;
	big_level_t iack_level, ack_lvl = 0;
	int num_errors = 0, check_count = 0, vec_cnt = 0, cyc = 0;
	int lmap[18] = '{4, 5, 6, 18, 19, 20, 21, 14, 15, 16, 17, 7, 8, 9, 10, 11, 12, 13};
	int vmap[18] = '{9, 10, 8, 12, 13, 14, 15, 31, 31, 31, 31, 31, 31, 31, 31, 31, 31, 31};

	// 10 MHz clock
	initial forever #50 sys_clk = ~sys_clk;

	big_irq_gen #(.FILT_LEN(2)) big_irq_gen_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .acfail_n(fail_n[0]), .sysfail_n(fail_n[1]),
		.local_irq_inputs_n(lin_n), .vme_error_event(src[0]), .local_abort_event(src[1]),
		.dma_event(src[2]), .mailbox_accesses(src[6:3]), .location_monitor_hits(src[10:7]),
		.vector_acquired_levels(src[17:11]), .bus_grant(bus_grant),
		.iack_strobe(iack_strobe), .iack_level(iack_level), .iack_in_n(iack_in_n),
		.syscon(syscon), .local_irq_out_n(local_irq_out_n), .vme_irq_out_n(vme_irq_out_n),
		.vector_valid(vector_valid), .vector_data(vector_data));
	big_vme_handler big_vme_handler_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.vme_irq_out_n(vme_irq_out_n), .ack_go(ack_go), .ack_lvl(ack_lvl), .ack_dly(ack_dly),
		.chain_ok(chain_ok), .iack_strobe(iack_strobe), .iack_level(iack_level),
		.iack_in_n(iack_in_n));

	// Vector capture; the cycle ceiling cuts a hang short
	always @(posedge sys_clk) begin
		cyc++;
		if (vector_valid === 1'b1) begin
			vec_seen <= vector_data;
			vec_cnt++;
		end
		if (cyc == 6000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input big_addr_t a, input big_word_t d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data is only valid in the cycle after the strobe
	task automatic rd_chk(input big_addr_t a, input big_word_t e, input string n);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
		`CHK(n, e, rd_val)
	endtask
	task automatic ack(input big_level_t l, input logic ok, input logic [3:0] d);
		@(posedge sys_clk);
		ack_go <= 1'b1;
		ack_lvl <= l;
		chain_ok <= ok;
		ack_dly <= d;
		@(posedge sys_clk);
		ack_go <= 1'b0;
		tick(12);
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		tick(1);
		`CHK("lout", 8'hff, local_irq_out_n)
		`CHK("vout", 7'h7f, vme_irq_out_n)
		rd_chk(8'h3c, 32'h0, "unmapped");
		$display("test reset done");
		// Routed edge source on both sides
		wr(`BIG_OFF_LEN, 32'h40);
		wr(`BIG_OFF_LROUTE0, 32'h05000000);
		wr(`BIG_OFF_VEN, 32'h100);
		wr(`BIG_OFF_VROUTE1, 32'h3);
		@(posedge sys_clk);
		src[2] <= 1'b1;
		@(posedge sys_clk);
		src[2] <= 1'b0;
		tick(3);
		`CHK("lout", 8'hdf, local_irq_out_n)
		`CHK("vout", 7'h7b, vme_irq_out_n)
		wr(`BIG_OFF_LSTAT, 32'h0);
		tick(3);
		`CHK("lout", 8'hdf, local_irq_out_n)
		wr(`BIG_OFF_LSTAT, 32'h40);
		tick(3);
		`CHK("lout", 8'hff, local_irq_out_n)
		`CHK("vout", 7'h7b, vme_irq_out_n)
		wr(`BIG_OFF_VSTAT, 32'h100);
		tick(3);
		`CHK("vout", 7'h7f, vme_irq_out_n)
		$display("test route done");
		// Every edge source but the lock grant, locally disabled and routed to level zero
		wr(`BIG_OFF_LEN, 32'h0);
		wr(`BIG_OFF_VEN, `BIG_VEN_MASK);
		wr(`BIG_OFF_VROUTE1, 32'h0);
		for (int j = 0; j < 18; j++) begin
			@(posedge sys_clk);
			src[j] <= 1'b1;
			tick(3);
			rd_chk(`BIG_OFF_LSTAT, 32'h1 << lmap[j], "lstat");
			rd_chk(`BIG_OFF_VSTAT, (32'h1 << vmap[j]) & 32'hffffff, "vstat");
			`CHK("vout", 7'h7f, vme_irq_out_n)
			`CHK("lout", 8'hff, local_irq_out_n)
			wr(`BIG_OFF_LSTAT, 32'hffffffff);
			wr(`BIG_OFF_VSTAT, 32'hffffffff);
			rd_chk(`BIG_OFF_LSTAT, 32'h0, "edge");
			src[j] <= 1'b0;
		end
		// Lock grant with and without the lock request
		wr(`BIG_OFF_CTRL, 32'h1);
		@(posedge sys_clk);
		bus_grant <= 1'b1;
		tick(3);
		rd_chk(`BIG_OFF_LSTAT, 32'h400000, "lock");
		bus_grant <= 1'b0;
		wr(`BIG_OFF_LSTAT, 32'hffffffff);
		wr(`BIG_OFF_CTRL, 32'h0);
		@(posedge sys_clk);
		bus_grant <= 1'b1;
		tick(3);
		rd_chk(`BIG_OFF_LSTAT, 32'h0, "nolock");
		wr(`BIG_OFF_TRIG, 32'h1000000);
		rd_chk(`BIG_OFF_LSTAT, 32'h4, "lsoft");
		wr(`BIG_OFF_LSTAT, 32'hffffffff);
		$display("test sources done");
		// Power-fail and system-fail levels on output zero
		for (int k = 0; k < 2; k++) begin
			wr(`BIG_OFF_LEN, 32'h1 << k);
			@(posedge sys_clk);
			fail_n[k] <= 1'b0;
			tick(2);
			`CHK("lout", 8'hff, local_irq_out_n)
			tick(10);
			`CHK("lout", 8'hfe, local_irq_out_n)
			wr(`BIG_OFF_LSTAT, 32'h1 << k);
			tick(3);
			rd_chk(`BIG_OFF_LSTAT, 32'h1 << k, "fail");
			fail_n[k] <= 1'b1;
			tick(10);
			`CHK("lout", 8'hfe, local_irq_out_n)
			wr(`BIG_OFF_LSTAT, 32'h1 << k);
			tick(3);
			`CHK("lout", 8'hff, local_irq_out_n)
		end
		$display("test fail done");
		// Fixed-level software request and its acknowledge
		wr(`BIG_OFF_VECTOR, 32'ha5);
		rd_chk(`BIG_OFF_VECTOR, 32'ha4, "vector");
		wr(`BIG_OFF_LEN, 32'h8);
		wr(`BIG_OFF_LROUTE0, 32'h1000);
		wr(`BIG_OFF_TRIG, 32'h40000);
		tick(3);
		`CHK("vout", 7'h7d, vme_irq_out_n)
		ack(3'h2, 1'b0, 4'h5);
		`CHK("vcnt", 0, vec_cnt)
		ack(3'h2, 1'b1, 4'h0);
		`CHK("vcnt", 1, vec_cnt)
		`CHK("vec", 8'ha4, vec_seen)
		`CHK("vout", 7'h7f, vme_irq_out_n)
		`CHK("lout", 8'hfd, local_irq_out_n)
		rd_chk(`BIG_OFF_VSTAT, 32'h0, "vstat");
		$display("test soft done");
		// Level input and mappable software share level 4 under system control
		wr(`BIG_OFF_LSTAT, 32'hffffffff);
		lin_n[1] <= 1'b0;
		wr(`BIG_OFF_VROUTE0, 32'h40);
		wr(`BIG_OFF_VROUTE1, 32'h4000);
		wr(`BIG_OFF_TRIG, 32'h800);
		syscon <= 1'b1;
		tick(3);
		`CHK("vout", 7'h77, vme_irq_out_n)
		ack(3'h4, 1'b0, 4'h2);
		`CHK("vec", 8'ha4, vec_seen)
		rd_chk(`BIG_OFF_VSTAT, 32'h2, "vstat");
		`CHK("vout", 7'h77, vme_irq_out_n)
		ack(3'h4, 1'b0, 4'h0);
		`CHK("vec", 8'ha5, vec_seen)
		`CHK("vcnt", 3, vec_cnt)
		lin_n[1] <= 1'b1;
		wr(`BIG_OFF_VSTAT, 32'h2);
		tick(3);
		`CHK("vout", 7'h7f, vme_irq_out_n)
		$display("test shared done");
		close_out();
	end
endmodule // big_irq_gen_tb_top
